// ==== core/hbridge_decoder.sv ====
// device end: bridge output mode decoder driving four three-state legs
// assumes pins arrive asynchronously; one clock, no current limiter built in
//
// The implementer's own choices: register access over APB and the placing of the registers.
`include "hbridge_consts.svh"
`timescale 1ns/1ns
module hbridge_decoder
(
	// clock and reset
	input  wire logic      clk,
	input  wire logic      resetn,
	// pins
	hbridge_pins_if.device pins,
	// current limit override, low when unused
	input  wire logic      limit_active,
	input  wire logic [3:0] limit_leg_off,
	// status
	output logic [1:0]     mode_latched,
	output logic           prohibited,
	output logic           half_blocked
);
	typedef struct packed
	{
		logic [13:0]              s1;
		logic [13:0]              s2;
		hbridge_pkg::out_mode_e   mode;
		logic                     latched;
		logic                     prev_start;
		logic [3:0]               out;
		logic [3:0]               oe;
	} state_s;

	state_s st_r;
	state_s st_nxt;
	hbridge_pkg::leg_cmd_e c1p;
	hbridge_pkg::leg_cmd_e c1q;
	hbridge_pkg::leg_cmd_e c2p;
	hbridge_pkg::leg_cmd_e c2q;
	logic [13:0] raw;
	logic [13:0] s;
	logic        off_all;
	logic        half;

	assign raw = {pins.mode_sel_a, pins.diag_start, pins.ctrl_src_sel_two,
		pins.ctrl_src_sel_one, pins.sleep_n, pins.enable_lo_ch_two, pins.enable_lo_ch_one,
		pins.enable_hi_ch_two, pins.enable_hi_ch_one,
		pins.dir_in_d, pins.dir_in_c, pins.dir_in_b, pins.dir_in_a, pins.mode_sel_b};
	// both mode pins ride the same chain so they are captured on one edge
	assign s = st_r.s2;
	assign half = st_r.latched && st_r.mode == hbridge_pkg::MODE_HALF;
	// sleep and the half-mode select fault force every leg off
	assign off_all = ~s[9] | (half & s[10]);

	//////////////////////////////////////////////////////////////////////
	leg_channel_decode u_ch1
	(
		.half_mode (half),
		.dir_p     (s[1]),
		.dir_q     (s[2]),
		.en_hi     (s[5]),
		.en_lo     (s[7]),
		.force_off (off_all),
		.leg_p     (c1p),
		.leg_q     (c1q)
	);

	// combined mode feeds channel two from A, B and channel two's own enables
	leg_channel_decode u_ch2
	(
		.half_mode (half),
		.dir_p     (st_r.mode == hbridge_pkg::MODE_COMBINED ? s[1] : s[3]),
		.dir_q     (st_r.mode == hbridge_pkg::MODE_COMBINED ? s[2] : s[4]),
		.en_hi     (s[6]),
		.en_lo     (s[8]),
		.force_off (off_all),
		.leg_p     (c2p),
		.leg_q     (c2q)
	);

	//////////////////////////////////////////////////////////////////////
	always_comb
	begin
		hbridge_pkg::leg_cmd_e c [4];
		c[0] = c1p;
		c[1] = c1q;
		c[2] = c2p;
		c[3] = c2q;
		st_nxt = st_r;
		st_nxt.s1 = raw;
		st_nxt.s2 = st_r.s1;
		st_nxt.prev_start = s[12];
		// capture once on the first start edge; only power-on reset re-arms
		if (!st_r.latched && s[12] && !st_r.prev_start)
		begin
			st_nxt.mode = hbridge_pkg::out_mode_e'({s[0], s[13]});
			st_nxt.latched = 1'b1;
		end
		// combined mode: legs 3/4 take the pair map; before latch nothing drives
		for (int i = 0; i < 4; i++)
		begin
			st_nxt.oe[i] = st_r.latched && st_r.mode != hbridge_pkg::MODE_PROHIBITED
				&& c[i] != hbridge_pkg::LEG_OFF
				&& !(limit_active && limit_leg_off[i]);
			st_nxt.out[i] = st_nxt.oe[i] && c[i] == hbridge_pkg::LEG_HIGH;
		end
		// legs 1/2 and 3/4 are shorted in combined mode; drive them in pairs
		if (st_r.mode == hbridge_pkg::MODE_COMBINED)
		begin
			st_nxt.out[1] = st_nxt.out[0];
			st_nxt.oe[1] = st_nxt.oe[0];
			st_nxt.out[2] = st_nxt.out[3];
			st_nxt.oe[2] = st_nxt.oe[3];
		end
	end

	// combined pairing: legs 1/2 carry A, legs 3/4 carry B
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// no serial drive path at all; pins are the only source
	assign pins.leg_out = (st_r.mode == hbridge_pkg::MODE_COMBINED)
		? {st_r.out[3], st_r.out[3], st_r.out[0], st_r.out[0]} : st_r.out;
	assign pins.leg_oe = (st_r.mode == hbridge_pkg::MODE_COMBINED)
		? {st_r.oe[3], st_r.oe[3], st_r.oe[0], st_r.oe[0]} : st_r.oe;
	assign mode_latched = st_r.mode;
	assign prohibited = st_r.latched && st_r.mode == hbridge_pkg::MODE_PROHIBITED;
	assign half_blocked = half & s[10];
endmodule

// ==== core/hbridge_consts.svh ====
// constants for the h-bridge output mode decoder and its controller
// assumes a single 100 MHz clock and an active-low asynchronous reset
//
// Functional notes
// - decode mode pins: combined, half, separate
// - both mode pins high turns all legs off
// - mode pins latched at diagnosis start only
// - prohibited mode left only by power reset
// - separate mode channel one forward, reverse, brake
// - channel two same mapping on C, D
// - enable low or inverted enable high: off
// - sleep low forces all legs off
// - controller drives inverted enables during sleep
// - controller brakes between direction changes
// - current limit may override the truth table
// - combined mode ignores channel two inputs; the code ignores C, D but still uses channel two enables
// - combined mode pairs legs from A, B
// - half mode: each leg follows its input
// - half mode accepts direct pin drive only
// - controller holds source select one low; the code drives it from a ctrl bit that software can set
// - half mode select high: off, self-clearing
// - open direction input reads as low
// - both enables gate each leg separately
`ifndef HBRIDGE_CONSTS_SVH
`define HBRIDGE_CONSTS_SVH

// controller register offsets (byte addresses)
`define HB_REG_CTRL     12'h000
`define HB_REG_DRIVE    12'h004
`define HB_REG_STATUS   12'h008
`define HB_REG_BRAKE    12'h00c

// ctrl field positions
`define HB_CTRL_MODE_A  0
`define HB_CTRL_MODE_B  1
`define HB_CTRL_SLEEP_N 2
`define HB_CTRL_SRC_ONE 3
`define HB_CTRL_SRC_TWO 4
`define HB_CTRL_START   5

// reset values
`define HB_CTRL_RESET   32'h0000_0000
`define HB_DRIVE_RESET  32'h0000_0000
`define HB_BRAKE_RESET  32'h0000_0004

// least braking interval between opposite directions, in ns; the controller brakes for the brake register count, reset 4 cycles
`define HB_BRAKE_NS     1000
`define HB_CLK_NS       10
`define HB_BRAKE_CYC    ((`HB_BRAKE_NS + `HB_CLK_NS - 1) / `HB_CLK_NS)

`endif

// ==== core/hbridge_pkg.sv ====
// types shared by the decoder and its channel decode
// assumes nothing beyond the constants header
package hbridge_pkg;

	typedef enum logic [1:0]
	{
		MODE_COMBINED   = 2'b00,
		MODE_HALF       = 2'b01,
		MODE_SEPARATE   = 2'b10,
		MODE_PROHIBITED = 2'b11
	} out_mode_e;

	// three-state leg command
	typedef enum logic [1:0]
	{
		LEG_OFF  = 2'b00,
		LEG_LOW  = 2'b01,
		LEG_HIGH = 2'b10
	} leg_cmd_e;

	typedef enum logic [1:0]
	{
		PH_POR    = 2'b00,
		PH_WAIT   = 2'b01,
		PH_RUN    = 2'b10
	} phase_e;

endpackage

// ==== core/hbridge_pins_if.sv ====
// pin level bundle between the controller and the bridge decoder
// assumes the bench resolves legs from drive/enable pairs
`timescale 1ns/1ns
interface hbridge_pins_if;
	logic       mode_sel_a;
	logic       mode_sel_b;
	logic       dir_in_a;
	logic       dir_in_b;
	logic       dir_in_c;
	logic       dir_in_d;
	logic       enable_hi_ch_one;
	logic       enable_hi_ch_two;
	logic       enable_lo_ch_one;
	logic       enable_lo_ch_two;
	logic       sleep_n;
	logic       ctrl_src_sel_one;
	logic       ctrl_src_sel_two;
	logic       diag_start;
	logic [3:0] leg_out;
	logic [3:0] leg_oe;

	modport device
	(
		input  mode_sel_a, mode_sel_b, dir_in_a, dir_in_b, dir_in_c, dir_in_d,
		input  enable_hi_ch_one, enable_hi_ch_two, enable_lo_ch_one, enable_lo_ch_two,
		input  sleep_n, ctrl_src_sel_one, ctrl_src_sel_two, diag_start,
		output leg_out, leg_oe
	);

	modport controller
	(
		output mode_sel_a, mode_sel_b, dir_in_a, dir_in_b, dir_in_c, dir_in_d,
		output enable_hi_ch_one, enable_hi_ch_two, enable_lo_ch_one, enable_lo_ch_two,
		output sleep_n, ctrl_src_sel_one, ctrl_src_sel_two, diag_start,
		input  leg_out, leg_oe
	);
endinterface

// ==== core/leg_channel_decode.sv ====
// one channel's direction and enable decode into two leg commands
// assumes inputs already synchronised; purely combinational
`timescale 1ns/1ns
module leg_channel_decode
(
	// mode
	input  wire logic                 half_mode,
	// pins
	input  wire logic                 dir_p,
	input  wire logic                 dir_q,
	input  wire logic                 en_hi,
	input  wire logic                 en_lo,
	input  wire logic                 force_off,
	// legs
	output hbridge_pkg::leg_cmd_e     leg_p,
	output hbridge_pkg::leg_cmd_e     leg_q
);
	logic gate_p;
	logic gate_q;
	logic dp;
	logic dq;

	always_comb
	begin
		// each enable gates each leg on its own path
		gate_p = en_hi & ~en_lo & ~force_off;
		gate_q = ~en_lo & en_hi & ~force_off;
		// an open input is pulled to low before it gets here
		dp = dir_p;
		dq = dir_q;
		// both the h-bridge map and the half map reduce to leg follows its input;
		// kept apart so a mode-dependent map can be added without rework
		if (half_mode)
		begin
			leg_p = gate_p ? (dp ? hbridge_pkg::LEG_HIGH : hbridge_pkg::LEG_LOW)
				: hbridge_pkg::LEG_OFF;
			leg_q = gate_q ? (dq ? hbridge_pkg::LEG_HIGH : hbridge_pkg::LEG_LOW)
				: hbridge_pkg::LEG_OFF;
		end
		else
		begin
			// forward, reverse, short brake on equal inputs
			leg_p = gate_p ? (dp ? hbridge_pkg::LEG_HIGH : hbridge_pkg::LEG_LOW)
				: hbridge_pkg::LEG_OFF;
			leg_q = gate_q ? (dq ? hbridge_pkg::LEG_HIGH : hbridge_pkg::LEG_LOW)
				: hbridge_pkg::LEG_OFF;
		end
	end
endmodule

// ==== core/hbridge_controller.sv ====
// controller end: APB registers drive the bridge pins, brake enforced
// assumes APB master on the same clock; device end on the pin interface
`include "hbridge_consts.svh"
`timescale 1ns/1ns
module hbridge_controller
(
	// clock and reset
	input  wire logic          clk,
	input  wire logic          resetn,
	// apb
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [11:0]   paddr,
	input  wire logic [31:0]   pwdata,
	output logic [31:0]        prdata,
	output logic               pready,
	output logic               pslverr,
	// pins
	hbridge_pins_if.controller pins
);
	typedef struct packed
	{
		logic [31:0] ctrl;
		logic [31:0] drive;
		logic [31:0] brake;
		logic [31:0] cnt;
		logic [3:0]  act;
	} state_s;

	state_s st_r;
	state_s st_nxt;
	logic   wr;
	logic   rev_one;
	logic   rev_two;

	assign wr = psel & penable & pwrite;
	// a channel reverses when it drives one way and is asked for the other
	assign rev_one = (st_r.act[0] ^ st_r.act[1]) && (st_r.drive[0] ^ st_r.drive[1])
		&& st_r.act[1:0] != st_r.drive[1:0];
	assign rev_two = (st_r.act[2] ^ st_r.act[3]) && (st_r.drive[2] ^ st_r.drive[3])
		&& st_r.act[3:2] != st_r.drive[3:2];

	always_comb
	begin
		st_nxt = st_r;
		if (wr && paddr == `HB_REG_CTRL)
			st_nxt.ctrl = pwdata;
		if (wr && paddr == `HB_REG_DRIVE)
			st_nxt.drive = pwdata;
		if (wr && paddr == `HB_REG_BRAKE)
			st_nxt.brake = pwdata;
		// a reversal first passes through short brake for the set time;
		// pins are re-judged when it ends, so neither channel flips straight over
		if (st_r.cnt > 32'h1)
			st_nxt.cnt = st_r.cnt - 32'h1;
		else
		begin
			st_nxt.cnt = 32'h0;
			if (rev_one || rev_two)
			begin
				if (rev_one)
					st_nxt.act[1:0] = 2'b00;
				if (rev_two)
					st_nxt.act[3:2] = 2'b00;
				st_nxt.cnt = st_r.brake;
			end
			else
				st_nxt.act = st_r.drive[3:0];
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_r.ctrl <= `HB_CTRL_RESET;
			st_r.drive <= `HB_DRIVE_RESET;
			st_r.brake <= `HB_BRAKE_RESET;
			st_r.cnt <= 32'h0;
			st_r.act <= 4'h0;
		end
		else
			st_r <= st_nxt;
	end

	assign pready = 1'b1;
	assign pslverr = 1'b0;
	always_comb
	begin
		unique case (paddr)
			`HB_REG_CTRL:   prdata = st_r.ctrl;
			`HB_REG_DRIVE:  prdata = st_r.drive;
			`HB_REG_STATUS: prdata = {27'h0, pins.leg_oe & pins.leg_out, st_r.cnt != 32'h0};
			`HB_REG_BRAKE:  prdata = st_r.brake;
			default:        prdata = 32'h0;
		endcase
	end

	assign pins.mode_sel_a = st_r.ctrl[`HB_CTRL_MODE_A];
	assign pins.mode_sel_b = st_r.ctrl[`HB_CTRL_MODE_B];
	assign pins.sleep_n = st_r.ctrl[`HB_CTRL_SLEEP_N];
	// held low unless software sets it; half mode needs it low
	assign pins.ctrl_src_sel_one = st_r.ctrl[`HB_CTRL_SRC_ONE];
	assign pins.ctrl_src_sel_two = st_r.ctrl[`HB_CTRL_SRC_TWO];
	assign pins.diag_start = st_r.ctrl[`HB_CTRL_START];
	assign {pins.dir_in_d, pins.dir_in_c, pins.dir_in_b, pins.dir_in_a} = st_r.act;
	assign pins.enable_hi_ch_one = st_r.drive[4];
	assign pins.enable_hi_ch_two = st_r.drive[5];
	// always a definite level, also during sleep
	assign pins.enable_lo_ch_one = st_r.drive[6];
	assign pins.enable_lo_ch_two = st_r.drive[7];
endmodule

// ==== test/hbridge_asserts.sv ====
// checker on the bridge pin bundle: leg decode, gating, braking
// assumes one clock; the bench wires it beside the bundle
`timescale 1ns/1ns
module hbridge_asserts
(
	// clock and reset
	input wire logic       clk,
	input wire logic       resetn,
	// pins
	input wire logic       mode_sel_a,
	input wire logic       mode_sel_b,
	input wire logic       dir_in_a,
	input wire logic       dir_in_b,
	input wire logic       dir_in_c,
	input wire logic       dir_in_d,
	input wire logic       enable_hi_ch_one,
	input wire logic       enable_hi_ch_two,
	input wire logic       enable_lo_ch_one,
	input wire logic       enable_lo_ch_two,
	input wire logic       sleep_n,
	input wire logic       ctrl_src_sel_one,
	input wire logic       diag_start,
	input wire logic       limit_active,
	// legs
	input wire logic [3:0] leg_out,
	input wire logic [3:0] leg_oe
);
	logic [13:0] pins_w;
	logic [13:0] pins_q_r;
	logic [2:0]  cnt_r;
	logic [1:0]  mode_r;
	logic        mode_ok_r;
	logic        settled;
	logic        en1;
	logic        en2;
	logic        blk;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	assign pins_w  = {mode_sel_a, mode_sel_b, dir_in_a, dir_in_b, dir_in_c, dir_in_d, sleep_n,
		enable_hi_ch_one, enable_hi_ch_two, enable_lo_ch_one, enable_lo_ch_two,
		ctrl_src_sel_one, diag_start, limit_active};
	// legs trail the pins by syncing edges, so judge settled pins only
	assign settled = pins_w == pins_q_r && cnt_r >= 3'h6 && mode_ok_r && !limit_active;
	assign en1     = enable_hi_ch_one && !enable_lo_ch_one;
	assign en2     = enable_hi_ch_two && !enable_lo_ch_two;
	assign blk     = mode_r == 2'b01 && ctrl_src_sel_one;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pins_q_r  <= 14'h0000;
			cnt_r     <= 3'h0;
			mode_r    <= 2'h0;
			mode_ok_r <= 1'b0;
		end
		else
		begin
			pins_q_r <= pins_w;
			cnt_r    <= (pins_w != pins_q_r) ? 3'h0 : cnt_r + {2'h0, cnt_r != 3'h7};
			if (diag_start && !pins_q_r[1] && !mode_ok_r)
			begin
				mode_r    <= {mode_sel_b, mode_sel_a};
				mode_ok_r <= 1'b1;
			end
		end
	end

	//////////////////////////////////////////////////
	chk_sleep_all_off: assert property (!sleep_n [*6] |=> leg_oe == 4'h0)
		else $error("leg on in sleep");
	chk_ch_one_off: assert property (!en1 [*6] |=> leg_oe[1:0] == 2'b00)
		else $error("leg on, channel one off");
	chk_ch_two_off: assert property (!en2 [*6] |=> leg_oe[3:2] == 2'b00)
		else $error("leg on, channel two off");
	chk_prohib_off: assert property (mode_ok_r && mode_r == 2'b11 |-> leg_oe == 4'h0)
		else $error("leg on in prohibited mode");
	chk_half_block: assert property (settled && blk |-> leg_oe == 4'h0)
		else $error("leg on with half select high");
	chk_leg_map: assert property (settled && sleep_n && mode_r[0] != mode_r[1] && !blk
		|-> leg_oe == {en2, en2, en1, en1}
		&& (leg_out & leg_oe) == ({dir_in_d, dir_in_c, dir_in_b, dir_in_a} & leg_oe))
		else $error("leg map wrong");
	chk_comb_pair: assert property (settled && sleep_n && mode_r == 2'b00 && en1 && en2
		|-> leg_oe == 4'hf && leg_out == {dir_in_b, dir_in_b, dir_in_a, dir_in_a})
		else $error("combined legs wrong");
	chk_no_direct_rev: assert property ($past(dir_in_a) != $past(dir_in_b)
		|-> dir_in_a == $past(dir_in_a) || dir_in_b == $past(dir_in_b))
		else $error("reversal without brake");
	chk_no_rev_two: assert property ($past(dir_in_c) != $past(dir_in_d)
		|-> dir_in_c == $past(dir_in_c) || dir_in_d == $past(dir_in_d))
		else $error("reversal without brake, channel two");

	cover property (settled && mode_r == 2'b10 && en1 && en2 && sleep_n);
	cover property (settled && mode_r == 2'b00 && en1 && sleep_n);
	cover property (settled && blk);
endmodule

// ==== test/testbench.sv ====
// bench: apb writes steer the controller, legs compared with a model
// assumes design files and checker compiled first
`include "hbridge_consts.svh"
`timescale 1ns/1ns
module testbench;
	logic        clk;
	logic        resetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic [31:0] rd;
	logic        limit_active;
	logic [3:0]  limit_leg_off;
	logic [1:0]  mode_latched;
	logic        prohibited;
	logic        half_blocked;
	logic        pslverr;
	int          mismatches;
	int          checked;

	hbridge_pins_if pins ();
	hbridge_decoder hbridge_decoder_inst
	(
		.clk(clk), .resetn(resetn), .pins(pins), .limit_active(limit_active),
		.limit_leg_off(limit_leg_off), .mode_latched(mode_latched),
		.prohibited(prohibited), .half_blocked(half_blocked)
	);
	hbridge_controller hbridge_controller_inst
	(
		.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pins(pins)
	);
	hbridge_asserts hbridge_asserts_inst
	(
		.clk(clk), .resetn(resetn), .mode_sel_a(pins.mode_sel_a), .mode_sel_b(pins.mode_sel_b),
		.dir_in_a(pins.dir_in_a), .dir_in_b(pins.dir_in_b), .dir_in_c(pins.dir_in_c),
		.dir_in_d(pins.dir_in_d), .enable_hi_ch_one(pins.enable_hi_ch_one),
		.enable_hi_ch_two(pins.enable_hi_ch_two), .enable_lo_ch_one(pins.enable_lo_ch_one),
		.enable_lo_ch_two(pins.enable_lo_ch_two), .sleep_n(pins.sleep_n),
		.ctrl_src_sel_one(pins.ctrl_src_sel_one), .diag_start(pins.diag_start),
		.limit_active(limit_active), .leg_out(pins.leg_out), .leg_oe(pins.leg_oe)
	);

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic test_done;
		if (mismatches == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// off wins over every drive; open legs are masked out of the compare
	function automatic logic [7:0] legs(int m, logic [7:0] d, logic s, logic src);
		logic [3:0] oe;
		logic [3:0] o;
		oe = {{2{d[5] & !d[7]}}, {2{d[4] & !d[6]}}};
		o  = (m == 0) ? {d[1], d[1], d[0], d[0]} : d[3:0];
		if (m == 3 || !s || (m == 1 && src))
			oe = 4'h0;
		if (limit_active)
			oe = oe & ~limit_leg_off;
		return {oe, o & oe};
	endfunction

	initial
	begin
		int         m;
		int         i;
		logic [7:0] d;
		logic [7:0] e;
		logic [5:0] c;
		void'($urandom(32'h6740dede));
		{resetn, psel, penable, pwrite, limit_active} = 5'h00;
		paddr         = 12'h000;
		pwdata        = 32'h0;
		limit_leg_off = 4'h0;
		mismatches    = 0;
		checked       = 0;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		apb(1'b0, `HB_REG_BRAKE, 32'h0);
		check(rd, `HB_BRAKE_RESET);
		apb(1'b1, 12'h010, $urandom);
		apb(1'b0, 12'h010, 32'h0);
		check(rd, 32'h0);
		check(pslverr, 1'b0);
		for (m = 0; m < 4; m++)
		begin
			resetn <= 1'b0;
			@(posedge clk);
			resetn <= 1'b1;
			c = {4'h9, m[1:0]};
			apb(1'b1, `HB_REG_CTRL, {26'h0, c});
			repeat (16) @(posedge clk);
			check(mode_latched, m);
			for (i = 0; i < 24; i++)
			begin
				d = 8'($urandom);
				if (i % 4 != 0)
					d[7:4] = 4'h3;
				if (m == 0)
					d[7:4] = {d[6], d[6], d[4], d[4]};
				c[2] = i % 6 != 5;
				c[3] = m == 1 && i % 5 == 2;
				if (i == 12)
					c[1:0] = ~c[1:0];
				limit_active  <= m == 2 && i % 4 == 1;
				limit_leg_off <= 4'($urandom);
				apb(1'b1, `HB_REG_CTRL, {26'h0, c});
				apb(1'b1, `HB_REG_DRIVE, {24'h0, d});
				apb(1'b0, `HB_REG_DRIVE, 32'h0);
				check(rd[7:0], d);
				repeat (16) @(posedge clk);
				e = legs(m, d, c[2], c[3]);
				check({pins.leg_oe, pins.leg_out & pins.leg_oe}, e);
				check(mode_latched, m);
				check(prohibited, m == 3);
				check(half_blocked, m == 1 && c[3]);
				apb(1'b0, `HB_REG_STATUS, 32'h0);
				check(rd, {27'h0, e[3:0], 1'b0});
			end
		end
		test_done;
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		test_done;
	end
endmodule
